/* rtl/dgp_ports.sv */
// two gpio ports with analog config, pull-ups and change interrupt, apb slave
`timescale 1ns/1ps
`default_nettype none
module dgp_ports
  import dgp_pkg::*;
(
  // clock and reset
  input  wire logic            sys_clk,
  input  wire logic            reset_n,
  // apb slave
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [11:0]     paddr,
  input  wire logic [31:0]     pwdata,
  input  wire logic [3:0]      pstrb,
  output logic                 pready,
  output logic [31:0]          prdata,
  output logic                 pslverr,
  // first port pins
  input  wire logic [5:0]      first_pin_in,
  output dgp_first_drv_s       first_drv,
  output logic [5:0]           analog_sel,
  output logic                 vref_sel,
  // second port pins
  input  wire logic [7:0]      second_pin_in,
  output dgp_second_drv_s      second_drv,
  // alternate functions
  output logic                 timer_zero_clk_in,
  output logic                 slave_select_n,
  output logic                 prog_clk,
  output logic                 prog_data,
  output logic [5:0]           option_low,
  // interrupts and wake
  output logic                 change_int,
  output logic                 ext_int,
  output logic                 wake_req
);

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers

  // analog pin mask from the config field
  function automatic logic [5:0] analog_mask(input logic [2:0] cfg);
    logic [5:0] m;
    m = AN_MASK_NONE;
    unique case (cfg)
      3'h0, 3'h1, 3'h2, 3'h3: m = AN_MASK_ALL;
      3'h4, 3'h5:             m = AN_MASK_NO_SS;
      3'h6, 3'h7:             m = AN_MASK_NONE;
    endcase
    return m;
  endfunction : analog_mask

  // reference input selected by odd codes below 110
  function automatic logic vref_on(input logic [2:0] cfg);
    return cfg[0] & ~(cfg[2] & cfg[1]);
  endfunction : vref_on

  // read-modify-write merge; zero mask means full byte write
  function automatic logic [7:0] rmw(input logic [7:0] pins,
                                     input logic [7:0] data,
                                     input logic [7:0] mask);
    logic [7:0] m;
    m = (mask == 8'h00) ? 8'hFF : mask;
    return (pins & ~m) | (data & m);
  endfunction : rmw

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [5:0] first_s1;
  logic [5:0] first_s2;
  logic [5:0] first_s3;
  logic [5:0] first_filt;
  logic [7:0] second_s1;
  logic [7:0] second_s2;
  logic [7:0] second_s3;
  logic [7:0] second_filt;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      first_s1  <= 6'h00;
      first_s2  <= 6'h00;
      first_s3  <= 6'h00;
      second_s1 <= 8'h00;
      second_s2 <= 8'h00;
      second_s3 <= 8'h00;
    end else begin
      first_s1  <= first_pin_in;
      first_s2  <= first_s1;
      first_s3  <= first_s2;
      second_s1 <= second_pin_in;
      second_s2 <= second_s1;
      second_s3 <= second_s2;
    end
  end

  // a change counts once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < FIRST_W; gi++) begin : g_first_filt
      always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          first_filt[gi] <= 1'b0;
        end else if (first_s2[gi] == first_s3[gi]) begin
          first_filt[gi] <= first_s3[gi];
        end
      end
    end
    for (gi = 0; gi < SECOND_W; gi++) begin : g_second_filt
      always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          second_filt[gi] <= 1'b0;
        end else if (second_s2[gi] == second_s3[gi]) begin
          second_filt[gi] <= second_s3[gi];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // apb decode

  logic       setup_ph;
  logic       acc_done;
  logic       wr_done;
  logic       rd_done;
  logic [9:0] idx;
  logic       aligned;
  logic       mapped;
  logic       lane0;

  assign setup_ph = psel & ~penable;
  assign acc_done = psel & penable & pready;
  assign idx      = paddr[11:2];
  assign aligned  = (paddr[1:0] == 2'b00);
  assign lane0    = pstrb[0];
  assign mapped   = aligned &
                    ((idx == IDX_FIRST_PINS)  | (idx == IDX_SECOND_PINS) |
                     (idx == IDX_INT_CONTROL) | (idx == IDX_OPTION)      |
                     (idx == IDX_FIRST_DIR)   | (idx == IDX_SECOND_DIR)  |
                     (idx == IDX_ANALOG_CFG));
  assign wr_done  = acc_done & pwrite & mapped & lane0;
  assign rd_done  = acc_done & ~pwrite & mapped;

  ////////////////////////////////////////////////////////////////////////////
  // registers

  logic [5:0] first_lat;
  logic [5:0] first_dir;
  logic [2:0] pin_config_field;
  logic [7:0] second_lat;
  logic [7:0] second_dir;
  logic [7:0] option_reg;
  logic [5:0] first_read;
  logic [5:0] an_mask;
  logic [7:0] first_merge;

  assign an_mask     = analog_mask(pin_config_field);
  assign first_read  = first_filt & ~an_mask;
  assign first_merge = rmw({2'b00, first_read}, pwdata[7:0], pwdata[15:8]);

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      first_lat <= FIRST_LAT_RST;
    end else if (wr_done && idx == IDX_FIRST_PINS) begin
      first_lat <= first_merge[5:0];
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      first_dir <= FIRST_DIR_RST;
    end else if (wr_done && idx == IDX_FIRST_DIR) begin
      first_dir <= pwdata[5:0];
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_config_field <= CFG_RST;
    end else if (wr_done && idx == IDX_ANALOG_CFG) begin
      pin_config_field <= pwdata[2:0];
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      second_lat <= SECOND_LAT_RST;
    end else if (wr_done && idx == IDX_SECOND_PINS) begin
      second_lat <= rmw(second_filt, pwdata[7:0], pwdata[15:8]);
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      second_dir <= SECOND_DIR_RST;
    end else if (wr_done && idx == IDX_SECOND_DIR) begin
      second_dir <= pwdata[7:0];
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      option_reg <= OPTION_RST;
    end else if (wr_done && idx == IDX_OPTION) begin
      option_reg <= pwdata[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // change detection on the upper four pins

  logic [3:0] chg_ref;
  logic       second_access;
  logic       mismatch;
  logic       change_flag;
  logic       ext_flag;
  logic       ext_prev;
  logic       ext_edge;
  logic       flag_wr;

  assign second_access = acc_done & aligned & (idx == IDX_SECOND_PINS);
  assign mismatch = |((second_filt[7:CHG_LO] ^ chg_ref) &
                      second_dir[7:CHG_LO]);
  assign flag_wr  = wr_done & (idx == IDX_INT_CONTROL);

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      chg_ref <= 4'h0;
    end else if (second_access) begin
      chg_ref <= second_filt[7:CHG_LO];
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      change_flag <= 1'b0;
    end else if (mismatch) begin
      change_flag <= 1'b1;
    end else if (flag_wr && !pwdata[INT_CHANGE_FLAG]) begin
      change_flag <= 1'b0;
    end
  end

  // external interrupt edge on second port bit 0
  assign ext_edge = option_reg[OPT_EDGE_SEL] ?
                    (second_filt[EXT_BIT] & ~ext_prev) :
                    (~second_filt[EXT_BIT] & ext_prev);

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ext_prev <= 1'b0;
    end else begin
      ext_prev <= second_filt[EXT_BIT];
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ext_flag <= 1'b0;
    end else if (ext_edge) begin
      ext_flag <= 1'b1;
    end else if (flag_wr && !pwdata[INT_EXT_FLAG]) begin
      ext_flag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb answer, one access cycle

  logic [7:0] next_rdata;

  always_comb begin
    next_rdata = 8'h00;
    unique case (idx)
      IDX_FIRST_PINS:  next_rdata = {2'b00, first_read};
      IDX_FIRST_DIR:   next_rdata = {2'b00, first_dir};
      IDX_ANALOG_CFG:  next_rdata = {5'h00, pin_config_field};
      IDX_SECOND_PINS: next_rdata = second_filt;
      IDX_SECOND_DIR:  next_rdata = second_dir;
      IDX_OPTION:      next_rdata = option_reg;
      IDX_INT_CONTROL: next_rdata = {6'h00, ext_flag, change_flag};
      default:         next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup_ph;
      pslverr <= setup_ph & ~mapped;
      if (setup_ph && !pwrite && mapped) begin
        prdata <= {24'h00_0000, next_rdata};
      end else if (acc_done) begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drivers and alternate functions

  logic [7:0] next_pullup;
  logic [5:0] next_first_oe;

  always_comb begin
    next_first_oe         = ~first_dir;
    next_first_oe[OD_BIT] = ~first_dir[OD_BIT] & ~first_lat[OD_BIT];
  end

  assign next_pullup = {SECOND_W{~option_reg[OPT_PULLUP_DIS_N]}} &
                       second_dir;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      first_drv <= '0;
    end else begin
      first_drv.out         <= first_lat;
      first_drv.out[OD_BIT] <= 1'b0;
      first_drv.oe          <= next_first_oe;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      second_drv <= '0;
    end else begin
      second_drv.out       <= second_lat;
      second_drv.oe        <= ~second_dir;
      second_drv.pullup_en <= next_pullup;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      analog_sel <= AN_MASK_ALL;
      vref_sel   <= 1'b0;
    end else begin
      analog_sel <= an_mask;
      vref_sel   <= vref_on(pin_config_field);
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      timer_zero_clk_in <= 1'b0;
      slave_select_n    <= 1'b1;
      prog_clk          <= 1'b0;
      prog_data         <= 1'b0;
      option_low        <= OPTION_RST[5:0];
    end else begin
      timer_zero_clk_in <= first_filt[OD_BIT];
      slave_select_n    <= first_filt[SS_BIT];
      prog_clk          <= second_filt[PCLK_BIT];
      prog_data         <= second_filt[PDAT_BIT];
      option_low        <= option_reg[5:0];
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      change_int <= 1'b0;
      ext_int    <= 1'b0;
      wake_req   <= 1'b0;
    end else begin
      change_int <= change_flag;
      ext_int    <= ext_flag;
      wake_req   <= change_flag;
    end
  end

endmodule : dgp_ports
`default_nettype wire

/* shared/dgp_pkg.sv */
// constants, field layouts and carrier types for the dual gpio port block
// Notes on behaviour
// - first port: six pins, direction 1 tristates the driver, 0 drives latch
// - first port read returns pin levels; write only updates output latch
// - port writes are read-modify-write: sample pins, modify, store into latch
// - first port bit 4 shares timer clock input; output is open drain only
// - three-bit pin configuration field picks digital, analog or reference; resets 000
// - after power-on the analog-capable first port pins are analog and read 0
// - direction bits still drive pins in analog mode; software keeps them set
// - first port direction: six bits reset to ones, two upper bits read zero
// - first port bit 5 is also slave select input and analog input
// - second port: eight pins, direction 1 input tristated, 0 drives latch
// - clearing pull-up disable bit 7 of option enables the pull-ups of all second port input pins
// - a second port pin set as output has its pull-up switched off
// - power-on reset leaves all second port pull-ups disabled
// - upper four inputs compared with reference from last second port access; OR sets flag bit 0
// - upper pins configured as outputs never take part in the change comparison
// - the change interrupt can wake the device from sleep
// - any second port access refreshes reference; flag cleared only by software write
// - persisting mismatch keeps setting the flag, so a clear does not hold
// - second port bit 0 is external interrupt input; edge chosen by option bit 6
// - second port bits 6 and 7 carry serial programming clock and data
// - second port direction and option registers reset to all ones
package dgp_pkg;

  // register indices; byte address is four times the index
  localparam logic [9:0] IDX_FIRST_PINS  = 10'h005;
  localparam logic [9:0] IDX_SECOND_PINS = 10'h006;
  localparam logic [9:0] IDX_INT_CONTROL = 10'h00B;
  localparam logic [9:0] IDX_OPTION      = 10'h081;
  localparam logic [9:0] IDX_FIRST_DIR   = 10'h085;
  localparam logic [9:0] IDX_SECOND_DIR  = 10'h086;
  localparam logic [9:0] IDX_ANALOG_CFG  = 10'h09F;

  // widths
  localparam int FIRST_W  = 6;
  localparam int SECOND_W = 8;
  localparam int CFG_W    = 3;

  // reset values
  localparam logic [5:0] FIRST_DIR_RST  = 6'h3F;
  localparam logic [7:0] SECOND_DIR_RST = 8'hFF;
  localparam logic [7:0] OPTION_RST     = 8'hFF;
  localparam logic [2:0] CFG_RST        = 3'h0;
  localparam logic [5:0] FIRST_LAT_RST  = 6'h00;
  localparam logic [7:0] SECOND_LAT_RST = 8'h00;

  // field positions
  localparam int OPT_PULLUP_DIS_N = 7;
  localparam int OPT_EDGE_SEL     = 6;
  localparam int INT_CHANGE_FLAG  = 0;
  localparam int INT_EXT_FLAG     = 1;
  localparam int OD_BIT           = 4;
  localparam int SS_BIT           = 5;
  localparam int REF_BIT          = 3;
  localparam int EXT_BIT          = 0;
  localparam int PCLK_BIT         = 6;
  localparam int PDAT_BIT         = 7;
  localparam int CHG_LO           = 4;

  // analog selection masks of the first port
  localparam logic [5:0] AN_MASK_ALL    = 6'h2F;
  localparam logic [5:0] AN_MASK_NO_SS  = 6'h0B;
  localparam logic [5:0] AN_MASK_NONE   = 6'h00;

  // pin drive carriers
  typedef struct packed {
    logic [5:0] out;
    logic [5:0] oe;
  } dgp_first_drv_s;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] pullup_en;
  } dgp_second_drv_s;

endpackage : dgp_pkg

/* tb/dgp_board.sv */
// board model resolving the levels on both ports
`timescale 1ns/1ps
`default_nettype none
module dgp_board
  import dgp_pkg::*;
(
  // clock
  input wire logic            sys_clk,
  // device drive
  input wire dgp_first_drv_s  first_drv,
  input wire dgp_second_drv_s second_drv,
  // board drivers
  input wire logic [5:0]      ext_a,
  input wire logic [5:0]      ext_a_en,
  input wire logic [7:0]      ext_b,
  input wire logic [7:0]      ext_b_en,
  // pin levels
  output logic [5:0]          first_pin_in,
  output logic [7:0]          second_pin_in
);
  logic [5:0] a_last = 6'h00;
  logic [7:0] b_last = 8'h00;
  always_ff @(posedge sys_clk) begin
    a_last <= first_pin_in;
    b_last <= second_pin_in;
  end
  // floating pins wander; open drain pin has a board pull-up
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      first_pin_in[i] = first_drv.oe[i] ? first_drv.out[i] : ext_a_en[i] ? ext_a[i] :
                        (i == OD_BIT) ? 1'b1 : ~a_last[i];
    end
    for (int i = 0; i < 8; i++) begin
      second_pin_in[i] = second_drv.oe[i] ? second_drv.out[i] : ext_b_en[i] ? ext_b[i] :
                         second_drv.pullup_en[i] ? 1'b1 : ~b_last[i];
    end
  end
endmodule : dgp_board
`default_nettype wire

/* tb/dgp_ports_tb.sv */
// self-checking bench for the dual gpio port block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) n_compared++; if ((g) !== (e)) begin n_errors++; $display("wrong value %s exp %h got %h", n, e, g); end
module dgp_ports_tb
  import dgp_pkg::*;
;
  logic            sys_clk, reset_n, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0]     paddr;
  logic [31:0]     pwdata, prdata;
  logic [3:0]      pstrb;
  logic [5:0]      first_pin_in, analog_sel, option_low, ext_a, ext_a_en;
  logic [7:0]      second_pin_in, ext_b, ext_b_en, rd;
  logic            vref_sel, tzc, ssn, prog_clk, prog_data, change_int, ext_int, wake_req;
  dgp_first_drv_s  first_drv;
  dgp_second_drv_s second_drv;
  int              n_errors, n_compared;

  dgp_ports u_dgp_ports (.sys_clk(sys_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .first_pin_in(first_pin_in), .first_drv(first_drv),
    .analog_sel(analog_sel), .vref_sel(vref_sel), .second_pin_in(second_pin_in),
    .second_drv(second_drv), .timer_zero_clk_in(tzc), .slave_select_n(ssn),
    .prog_clk(prog_clk), .prog_data(prog_data), .option_low(option_low),
    .change_int(change_int), .ext_int(ext_int), .wake_req(wake_req));
  dgp_board u_dgp_board (.sys_clk(sys_clk), .first_drv(first_drv), .second_drv(second_drv),
    .ext_a(ext_a), .ext_a_en(ext_a_en), .ext_b(ext_b), .ext_b_en(ext_b_en),
    .first_pin_in(first_pin_in), .second_pin_in(second_pin_in));

  //////////////////////////////////////////////////////////////////////////////
  task automatic apb(input logic w, input logic [9:0] idx, input logic [15:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {16'h0000, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic t_reset();
    apb(0, IDX_FIRST_DIR, 16'h0);
    `CHK("first dir", 8'h3F, rd)
    apb(0, IDX_SECOND_DIR, 16'h0);
    `CHK("second dir", 8'hFF, rd)
    apb(0, IDX_FIRST_PINS, 16'h0);
    `CHK("first pins", 8'h10, rd)
    apb(0, IDX_OPTION, 16'h0);
    `CHK("option", 8'hFF, rd)
    apb(0, IDX_ANALOG_CFG, 16'h0);
    `CHK("config", 8'h00, rd)
    `CHK("pull-ups", 8'h00, second_drv.pullup_en)
    apb(0, 10'h3FF, 16'h0);
    `CHK("unmapped err", 1'b1, err)
    `CHK("unmapped data", 8'h00, rd)
    $display("test reset done");
  endtask : t_reset

  task automatic t_config();
    logic [5:0] m;
    for (int c = 0; c < 8; c++) begin
      m = c < 4 ? 6'h2F : c < 6 ? 6'h0B : 6'h00;
      apb(1, IDX_ANALOG_CFG, 16'(c));
      apb(0, IDX_FIRST_PINS, 16'h0);
      `CHK("pins by config", {2'b00, 6'h3F & ~m}, rd)
      `CHK("analog sel", m, analog_sel)
      `CHK("vref sel", 1'(c % 2 == 1 && c < 6), vref_sel)
    end
    $display("test config done");
  endtask : t_config

  task automatic t_first_port_pins();
    apb(1, IDX_FIRST_DIR, 16'h00FF);
    apb(0, IDX_FIRST_DIR, 16'h0);
    `CHK("dir upper", 8'h3F, rd)
    ext_a_en <= 6'h00;
    apb(1, IDX_FIRST_PINS, 16'h003F);
    apb(1, IDX_FIRST_DIR, 16'h0000);
    repeat (12) @(posedge sys_clk);
    `CHK("drive out", 6'h2F, first_drv.out)
    `CHK("drive oe", 4'hF, first_drv.oe[3:0])
    apb(0, IDX_FIRST_PINS, 16'h0);
    `CHK("pins driven", 8'h3F, rd)
    apb(1, IDX_FIRST_DIR, 16'h0001);
    ext_a <= 6'h00;
    ext_a_en <= 6'h01;
    repeat (12) @(posedge sys_clk);
    apb(1, IDX_FIRST_PINS, 16'h0200);
    apb(1, IDX_FIRST_DIR, 16'h0000);
    ext_a_en <= 6'h00;
    repeat (12) @(posedge sys_clk);
    apb(0, IDX_FIRST_PINS, 16'h0);
    `CHK("pins after rmw", 8'h3C, rd)
    apb(1, IDX_FIRST_PINS, 16'h3000);
    repeat (12) @(posedge sys_clk);
    `CHK("od pulls low", 1'b1, first_drv.oe[OD_BIT])
    `CHK("timer clock pin", 1'b0, tzc)
    `CHK("slave select", 1'b0, ssn)
    apb(1, IDX_FIRST_DIR, 16'h003F);
    $display("test first port done");
  endtask : t_first_port_pins

  task automatic t_second_port_pins();
    apb(1, IDX_OPTION, 16'h007F);
    repeat (4) @(posedge sys_clk);
    `CHK("pull-ups on", 8'hFF, second_drv.pullup_en)
    apb(1, IDX_SECOND_DIR, 16'h000F);
    apb(1, IDX_SECOND_PINS, 16'h00A5);
    repeat (12) @(posedge sys_clk);
    `CHK("pull-ups inputs", 8'h0F, second_drv.pullup_en)
    `CHK("second oe", 8'hF0, second_drv.oe)
    apb(0, IDX_SECOND_PINS, 16'h0);
    `CHK("second pins", 8'hAF, rd)
    apb(1, IDX_OPTION, 16'h00FF);
    apb(1, IDX_SECOND_DIR, 16'h00FF);
    $display("test second port done");
  endtask : t_second_port_pins

  task automatic t_change();
    ext_b <= 8'h00;
    ext_b_en <= 8'hFF;
    repeat (12) @(posedge sys_clk);
    apb(0, IDX_SECOND_PINS, 16'h0);
    apb(1, IDX_INT_CONTROL, 16'h0);
    repeat (8) @(posedge sys_clk);
    `CHK("change idle", 1'b0, change_int)
    ext_b[7] <= 1'b1;
    for (int n = 0; n < 30 && change_int !== 1'b1; n++) @(posedge sys_clk);
    `CHK("change set", 1'b1, change_int)
    `CHK("wake", 1'b1, wake_req)
    apb(1, IDX_INT_CONTROL, 16'h0);
    repeat (6) @(posedge sys_clk);
    `CHK("clear refused", 1'b1, change_int)
    apb(0, IDX_SECOND_PINS, 16'h0);
    apb(1, IDX_INT_CONTROL, 16'h0);
    repeat (6) @(posedge sys_clk);
    `CHK("cleared", 1'b0, change_int)
    ext_b[3] <= 1'b1;
    repeat (12) @(posedge sys_clk);
    `CHK("lower pin", 1'b0, change_int)
    apb(1, IDX_SECOND_DIR, 16'h007F);
    ext_b_en <= 8'h7F;
    apb(1, IDX_SECOND_PINS, 16'h0000);
    repeat (12) @(posedge sys_clk);
    `CHK("output pin", 1'b0, change_int)
    $display("test change done");
  endtask : t_change

  task automatic t_ext();
    apb(1, IDX_SECOND_DIR, 16'h00FF);
    ext_b_en <= 8'hFF;
    for (int e = 0; e < 2; e++) begin
      apb(1, IDX_OPTION, e == 1 ? 16'h00FF : 16'h00BF);
      ext_b[0] <= 1'(e == 0);
      repeat (12) @(posedge sys_clk);
      apb(1, IDX_INT_CONTROL, 16'h0);
      repeat (6) @(posedge sys_clk);
      `CHK("ext idle", 1'b0, ext_int)
      ext_b[0] <= 1'(e == 1);
      for (int n = 0; n < 30 && ext_int !== 1'b1; n++) @(posedge sys_clk);
      `CHK("ext edge", 1'b1, ext_int)
    end
    $display("test external interrupt done");
  endtask : t_ext

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : summarize

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  initial begin
    #500000;
    n_errors++;
    summarize();
  end
  initial begin
    {reset_n, psel, penable, pwrite, paddr, pwdata} = '0;
    pstrb = 4'h1;
    ext_a = 6'h3F;
    ext_a_en = 6'h3F;
    ext_b = 8'h00;
    ext_b_en = 8'h00;
    n_errors = 0;
    n_compared = 0;
    repeat (8) @(posedge sys_clk);
    reset_n <= 1'b1;
    t_reset();
    t_config();
    t_first_port_pins();
    t_second_port_pins();
    t_change();
    t_ext();
    summarize();
  end
endmodule : dgp_ports_tb
`default_nettype wire

/* tb/dgp_properties.sv */
// port-level checker for the dual gpio port block
`timescale 1ns/1ps
`default_nettype none
module dgp_properties
  import dgp_pkg::*;
(
  // clock and reset
  input wire logic            sys_clk,
  input wire logic            reset_n,
  // apb
  input wire logic            pwrite,
  input wire logic            psel,
  input wire logic            penable,
  input wire logic [11:0]     paddr,
  input wire logic            pready,
  input wire logic [31:0]     prdata,
  input wire logic            pslverr,
  // pins and flags
  input wire dgp_first_drv_s  first_drv,
  input wire logic [5:0]      analog_sel,
  input wire logic [7:0]      second_pin_in,
  input wire dgp_second_drv_s second_drv,
  input wire logic            prog_clk,
  input wire logic            prog_data,
  input wire logic [5:0]      option_low,
  input wire logic            change_int,
  input wire logic            wake_req
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  logic rd_ok;
  assign rd_ok = pready && !pwrite && !pslverr;
  chk_od_low: assert property (!(first_drv.oe[OD_BIT] && first_drv.out[OD_BIT]))
    else $error("open drain pin driven high");
  chk_pullup_gate: assert property (second_drv.pullup_en == 8'h00 || second_drv.pullup_en == ~second_drv.oe)
    else $error("pull-up enable inconsistent");
  chk_dir_upper: assert property (rd_ok && paddr[11:2] == IDX_FIRST_DIR |-> prdata[31:6] == 26'h0)
    else $error("direction upper bits not zero");
  chk_analog_zero: assert property (rd_ok && paddr[11:2] == IDX_FIRST_PINS |-> (prdata[5:0] & analog_sel) == 6'h00)
    else $error("analog pin read not zero");
  chk_wake_follows: assert property (change_int |-> wake_req)
    else $error("change without wake");
  chk_clear_only: assert property ($fell(change_int) |-> $past(psel && penable && pwrite && paddr[11:2] == IDX_INT_CONTROL, 2))
    else $error("change flag fell without clear");
  chk_prog_copy: assert property (($stable(second_pin_in[PCLK_BIT]) && $stable(second_pin_in[PDAT_BIT]))[*8] |-> prog_clk == second_pin_in[PCLK_BIT] && prog_data == second_pin_in[PDAT_BIT])
    else $error("programming pins not copied");
  chk_out_excluded: assert property ((second_drv.oe[7:CHG_LO] == 4'hF)[*2] ##0 !change_int |=> !change_int)
    else $error("output pins raised change");
  chk_reset_vals: assert property ($rose(reset_n) |-> option_low == 6'h3F && second_drv.pullup_en == 8'h00 && second_drv.oe == 8'h00)
    else $error("reset values wrong");
endmodule : dgp_properties
bind dgp_ports dgp_properties u_dgp_properties (.sys_clk(sys_clk), .reset_n(reset_n),
  .pwrite(pwrite), .psel(psel), .penable(penable), .paddr(paddr), .pready(pready),
  .prdata(prdata), .pslverr(pslverr), .first_drv(first_drv), .analog_sel(analog_sel),
  .second_pin_in(second_pin_in), .second_drv(second_drv), .prog_clk(prog_clk),
  .prog_data(prog_data), .option_low(option_low), .change_int(change_int), .wake_req(wake_req));
`default_nettype wire
